//--- logic/ilec_pkg.sv
// Package for the interrupt latch and enable controller.
// Assumes an 8-bit special-function bus from the CPU core and a synchronous core clock.
package ilec_pkg;
    // Special-function byte addresses
    localparam logic [7:0] ILEC_ADDR_EN_LO = 8'h3A;
    localparam logic [7:0] ILEC_ADDR_EN_HI = 8'h3B;
    localparam logic [7:0] ILEC_ADDR_PEND_LO = 8'h3C;
    localparam logic [7:0] ILEC_ADDR_PEND_HI = 8'h3D;
    // Field positions and source indices
    localparam int ILEC_MEF_BIT = 0;
    localparam int ILEC_SRC_TRAP = 2;
    localparam int ILEC_SRC_WDT = 3;
    localparam int ILEC_SRC_EXT0 = 4;
    localparam int ILEC_SRC_LAST = 15;
    // Reset values
    localparam logic [15:0] ILEC_EN_RST = 16'h0000;
    localparam logic [15:0] ILEC_LATCH_RST = 16'h0000;
    // Latch bits software may clear (2 and 3 are protected, 0 and 1 do not exist)
    localparam logic [15:0] ILEC_SW_CLR_MASK = 16'hFFF0;
    // Implemented latch bits (2..15)
    localparam logic [15:0] ILEC_LATCH_MASK = 16'hFFFC;
    // Vector addresses
    localparam logic [15:0] ILEC_VEC_RESET = 16'hFFFE;
    localparam logic [15:0] ILEC_VEC_SOFT = 16'hFFFC;
    localparam logic [15:0] ILEC_VEC_TRAP = 16'hFFFA;
    localparam logic [15:0] ILEC_VEC_WDT = 16'hFFF8;
    localparam logic [15:0] ILEC_VEC_MASK_TOP = 16'hFFF6;
    // Acceptance processing length in machine cycles
    localparam logic [3:0] ILEC_ACCEPT_CYCLES = 4'h8;

    // Special-function bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ilec_sfr_s;

    // Core-side control events
    typedef struct packed {
        logic instr_last;   // final cycle of the current instruction
        logic enable_op;    // enable_irq_op
        logic disable_op;   // disable_irq_op
        logic return_op;    // maskable or nonmaskable return
        logic return_mef;   // master enable value restored from stack
    } ilec_core_s;
endpackage

//--- logic/ilec_prio.sv
// Fixed-priority picker over the gated request vector.
// Assumes bit 0 is unused, bit 1 is the software trap path, higher index means lower priority.
`timescale 1ns/1ns
module ilec_prio #(
    parameter int N = 16
)
(
    // Requests
    input wire logic [N-1:0] req,
    // Winner
    output logic found,
    output logic [3:0] index
);
    // Lowest index wins
    always_comb
    begin
        found = 1'b0;
        index = 4'h0;
        for (int i = N - 1; i >= 1; i--)
        begin
            if (req[i])
            begin
                found = 1'b1;
                index = 4'(i);
            end
        end
    end
endmodule

//--- logic/ilec_top.sv
// Interrupt latch and enable controller: latches, enables, priority and vector.
// Assumes the CPU core drives sfr bus, instruction boundary and return events on clock.
`timescale 1ns/1ns
module ilec_top
    import ilec_pkg::*;
#(
    parameter int N_SRC = 16
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Special-function register port
    input wire ilec_pkg::ilec_sfr_s sfr,
    output logic [7:0] sfr_rdata,
    // Core control events
    input wire ilec_pkg::ilec_core_s core,
    input wire logic software_trap,
    input wire logic illegal_opcode_trap,
    // Source request pulses
    input wire logic bad_fetch_trap,
    input wire logic watchdog_irq,
    input wire logic ext_irq_zero,
    input wire logic ext_irq_one,
    input wire logic time_base_irq,
    input wire logic timer_three_irq,
    input wire logic timer_four_irq,
    input wire logic converter_done_irq,
    input wire logic ext_irq_five,
    input wire logic [2:0] reserved_irq,
    // Configuration from other blocks
    input wire logic ext_zero_pin_enable,
    input wire logic trap_reset_select,
    // Towards the core
    output logic accept_busy,
    output logic accept_done,
    output logic [15:0] vector_addr,
    output logic stacked_mef,
    output logic reset_request
);
    import ilec_pkg::*;

    typedef enum logic [1:0] {ILEC_IDLE, ILEC_ACCEPT} ilec_state_e;

    logic [15:0] request_latch_q;
    logic [15:0] enable_register_q;
    logic [15:0] set_vec;
    logic [15:0] sw_clr;
    logic [15:0] gated;
    logic [15:0] ack_clr;
    logic [15:0] mask_en;
    logic master_enable_flag;
    logic win_found;
    logic [3:0] win_index;
    logic [3:0] cyc_q;
    logic [3:0] src_q;
    ilec_state_e state_q;
    logic take;
    logic take_undef;

    // Vector for a source index; software and illegal opcode share index 1
    function automatic logic [15:0] vec_of(input logic [3:0] idx);
        logic [15:0] v;
        v = ILEC_VEC_SOFT;
        if (idx == 4'(ILEC_SRC_TRAP))
            v = ILEC_VEC_TRAP;
        else if (idx == 4'(ILEC_SRC_WDT))
            v = ILEC_VEC_WDT;
        else if (idx >= 4'(ILEC_SRC_EXT0))
            v = ILEC_VEC_MASK_TOP - {11'h000, idx - 4'(ILEC_SRC_EXT0), 1'b0};
        return v;
    endfunction

    assign master_enable_flag = enable_register_q[ILEC_MEF_BIT];

    // Hardware request events; reserved slots 7 to 9 wired to reserved_irq, slots 13 and 14 tied low
    always_comb
    begin
        set_vec = 16'h0000;
        // While the select bit is set, trap and watchdog go out as reset instead
        set_vec[2] = bad_fetch_trap & ~trap_reset_select;
        set_vec[3] = watchdog_irq & ~trap_reset_select;
        set_vec[4] = ext_irq_zero;
        set_vec[5] = ext_irq_one;
        set_vec[6] = time_base_irq;
        set_vec[9:7] = reserved_irq;
        set_vec[10] = timer_three_irq;
        set_vec[11] = timer_four_irq;
        set_vec[12] = converter_done_irq;
        set_vec[13] = 1'b0;
        set_vec[14] = 1'b0;
        set_vec[15] = ext_irq_five;
    end

    assign reset_request = trap_reset_select & (bad_fetch_trap | watchdog_irq);

    // Software clear: each written zero in an unprotected position
    always_comb
    begin
        sw_clr = 16'h0000;
        if (sfr.wr && sfr.addr == ILEC_ADDR_PEND_LO)
            sw_clr[7:0] = ~sfr.wdata & ILEC_SW_CLR_MASK[7:0];
        else if (sfr.wr && sfr.addr == ILEC_ADDR_PEND_HI)
            sw_clr[15:8] = ~sfr.wdata & ILEC_SW_CLR_MASK[15:8];
    end

    // Gating: maskable need master and own flag, non-maskable pass
    always_comb
    begin
        mask_en = {enable_register_q[15:4], 4'h0} & {16{master_enable_flag}};
        mask_en[ILEC_SRC_EXT0] = mask_en[ILEC_SRC_EXT0] & ext_zero_pin_enable;
        mask_en[3:2] = 2'b11;
        gated = request_latch_q & mask_en & ILEC_LATCH_MASK;
        gated[1] = software_trap;
    end

    ilec_prio #(
        .N(N_SRC)
    ) u_prio (
        .req(gated),
        .found(win_found),
        .index(win_index)
    );

    // Sampling happens only on an instruction's last cycle
    assign take = (state_q == ILEC_IDLE) && core.instr_last && win_found;
    // Illegal opcode does not wait for a boundary and aborts any acceptance
    assign take_undef = illegal_opcode_trap;

    always_comb
    begin
        ack_clr = 16'h0000;
        if (take && !take_undef && win_index >= 4'(ILEC_SRC_TRAP))
            ack_clr[win_index] = 1'b1;
    end

    // Request latches; set has priority over any clear in the same cycle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            request_latch_q <= ILEC_LATCH_RST;
        else
            request_latch_q <= ((request_latch_q & ~sw_clr & ~ack_clr) | set_vec) & ILEC_LATCH_MASK;
    end

    // Enable register; accept clears master flag, return restores it
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            enable_register_q <= ILEC_EN_RST;
        else
        begin
            if (sfr.wr && sfr.addr == ILEC_ADDR_EN_LO)
                enable_register_q[7:0] <= {sfr.wdata[7:4], 3'b000, sfr.wdata[0]};
            if (sfr.wr && sfr.addr == ILEC_ADDR_EN_HI)
                enable_register_q[15:8] <= sfr.wdata;
            if (core.enable_op)
                enable_register_q[ILEC_MEF_BIT] <= 1'b1;
            if (core.disable_op)
                enable_register_q[ILEC_MEF_BIT] <= 1'b0;
            if (core.return_op)
                enable_register_q[ILEC_MEF_BIT] <= core.return_mef;
            if (take || take_undef)
                enable_register_q[ILEC_MEF_BIT] <= 1'b0;
        end
    end

    // Acceptance sequencer: eight cycles after the boundary
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ILEC_IDLE;
            cyc_q <= 4'h0;
            src_q <= 4'h0;
        end
        else if (take_undef)
        begin
            state_q <= ILEC_ACCEPT;
            cyc_q <= ILEC_ACCEPT_CYCLES - 4'h1;
            src_q <= 4'h1;
        end
        else
        begin
            unique case (state_q)
                ILEC_IDLE:
                begin
                    if (take)
                    begin
                        state_q <= ILEC_ACCEPT;
                        cyc_q <= ILEC_ACCEPT_CYCLES - 4'h1;
                        src_q <= win_index;
                    end
                end
                ILEC_ACCEPT:
                begin
                    if (cyc_q == 4'h0)
                        state_q <= ILEC_IDLE;
                    else
                        cyc_q <= cyc_q - 4'h1;
                end
                default:
                    state_q <= ILEC_IDLE;
            endcase
        end
    end

    // Vector and stacked master flag captured at acceptance
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vector_addr <= ILEC_VEC_RESET;
            stacked_mef <= 1'b0;
        end
        else if (take_undef)
        begin
            vector_addr <= ILEC_VEC_SOFT;
            stacked_mef <= master_enable_flag;
        end
        else if (take)
        begin
            vector_addr <= vec_of(win_index);
            stacked_mef <= master_enable_flag;
        end
    end

    assign accept_busy = (state_q == ILEC_ACCEPT);
    assign accept_done = (state_q == ILEC_ACCEPT) && (cyc_q == 4'h0) && !take_undef;

    // Read data registered; unmapped addresses return zero
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            sfr_rdata <= 8'h00;
        else if (sfr.rd)
        begin
            unique case (sfr.addr)
                ILEC_ADDR_EN_LO: sfr_rdata <= enable_register_q[7:0];
                ILEC_ADDR_EN_HI: sfr_rdata <= enable_register_q[15:8];
                ILEC_ADDR_PEND_LO: sfr_rdata <= request_latch_q[7:0];
                ILEC_ADDR_PEND_HI: sfr_rdata <= request_latch_q[15:8];
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

    // Checks: latch set, clear and protection
    a_set_wins: assert property (@(posedge clock) disable iff (!rst_n)
        set_vec[5] |=> request_latch_q[5])
        else $error("latch 5 lost a request");
    a_prot_latch: assert property (@(posedge clock) disable iff (!rst_n)
        request_latch_q[3] && !take |=> request_latch_q[3])
        else $error("watchdog latch cleared by software");
    a_no_sw_set: assert property (@(posedge clock) disable iff (!rst_n)
        !request_latch_q[6] && !set_vec[6] |=> !request_latch_q[6])
        else $error("latch set without request");
    a_latch_none: assert property (@(posedge clock) disable iff (!rst_n)
        request_latch_q[1:0] == 2'b00)
        else $error("latch exists for an unlatched source");
    a_ack_clear: assert property (@(posedge clock) disable iff (!rst_n)
        take && !take_undef && win_index >= 4'h2 && !set_vec[win_index] |=> !request_latch_q[$past(win_index)])
        else $error("accepted latch not cleared");
    a_trap_held: assert property (@(posedge clock) disable iff (!rst_n)
        trap_reset_select && request_latch_q[3:2] == 2'b00 |=> request_latch_q[3:2] == 2'b00)
        else $error("trap latched while routed to reset");
    a_reset_out: assert property (@(posedge clock) disable iff (!rst_n)
        trap_reset_select && (bad_fetch_trap || watchdog_irq) |-> reset_request)
        else $error("trap not routed to reset");

    // Checks: gating, priority and vectors
    a_mask_gate: assert property (@(posedge clock) disable iff (!rst_n)
        take && win_index >= 4'h4 |-> master_enable_flag && enable_register_q[win_index])
        else $error("maskable taken while disabled");
    a_ext0_pin: assert property (@(posedge clock) disable iff (!rst_n)
        take && win_index == 4'h4 |-> ext_zero_pin_enable)
        else $error("external source 0 taken with pin enable off");
    a_prio_order: assert property (@(posedge clock) disable iff (!rst_n)
        take |-> (gated & ((16'h0001 << win_index) - 16'h0001)) == 16'h0000)
        else $error("lower priority source won");
    a_sw_direct: assert property (@(posedge clock) disable iff (!rst_n)
        core.instr_last && software_trap && !accept_busy && !illegal_opcode_trap |=>
            accept_busy && vector_addr == 16'hFFFC)
        else $error("software trap not taken");
    a_wdt_nomask: assert property (@(posedge clock) disable iff (!rst_n)
        core.instr_last && !accept_busy && !illegal_opcode_trap && !software_trap && request_latch_q[3:2] == 2'b10
            |=> accept_busy && vector_addr == 16'hFFF8)
        else $error("watchdog request blocked by enables");
    a_vec_map: assert property (@(posedge clock) disable iff (!rst_n)
        take && !take_undef && win_index == 4'hF |=> vector_addr == 16'hFFE0)
        else $error("lowest source vector wrong");
    a_undef_now: assert property (@(posedge clock) disable iff (!rst_n)
        illegal_opcode_trap |=> accept_busy && vector_addr == 16'hFFFC)
        else $error("illegal opcode trap not immediate");

    // Checks: master flag and register reads
    a_mef_clear: assert property (@(posedge clock) disable iff (!rst_n)
        take && !core.return_op |=> !master_enable_flag && stacked_mef == $past(master_enable_flag))
        else $error("master flag not stacked and cleared");
    a_return_mef: assert property (@(posedge clock) disable iff (!rst_n)
        core.return_op && !take && !take_undef |=> master_enable_flag == $past(core.return_mef))
        else $error("master flag not restored on return");
    a_rd_pend: assert property (@(posedge clock) disable iff (!rst_n)
        sfr.rd && sfr.addr == ILEC_ADDR_PEND_HI |=> sfr_rdata == $past(request_latch_q[15:8]))
        else $error("high pending byte read wrong");
    a_en_rd: assert property (@(posedge clock) disable iff (!rst_n)
        sfr.rd && sfr.addr == ILEC_ADDR_EN_LO |=> sfr_rdata[3:1] == 3'b000)
        else $error("unused enable bits read as one");

    // Checks: acceptance sequence; an illegal opcode restarts it, so plain takes only
    sequence s_take_plain;
        take && !take_undef;
    endsequence
    sequence s_accept_run;
        accept_busy [*8];
    endsequence
    a_accept_len: assert property (@(posedge clock) disable iff (!rst_n)
        s_take_plain |=> s_accept_run)
        else $error("acceptance shorter than eight cycles");
    a_accept_run: assert property (@(posedge clock) disable iff (!rst_n)
        s_take_plain ##1 (!take_undef [*8]) |-> accept_done ##1 !accept_busy)
        else $error("acceptance did not end after eight cycles");
    a_busy_hold: assert property (@(posedge clock) disable iff (!rst_n)
        accept_busy && !accept_done |=> accept_busy)
        else $error("acceptance dropped before its last cycle");
    a_done_once: assert property (@(posedge clock) disable iff (!rst_n)
        accept_done |=> !accept_done)
        else $error("acceptance end lasted more than one cycle");
    a_src_keep: assert property (@(posedge clock) disable iff (!rst_n)
        s_take_plain |=> src_q == $past(win_index))
        else $error("accepted source not recorded");
endmodule

//--- tb/ilec_core_model.sv
// CPU core stand-in: drives the special-function bus and instruction events.
// Assumes the controller samples on the rising edge; every change lands on the falling edge.
`timescale 1ns/1ns
module ilec_core_model
    import ilec_pkg::*;
(
    // Clock
    input wire logic clock,
    // Towards the controller
    output ilec_pkg::ilec_sfr_s sfr,
    output ilec_pkg::ilec_core_s core,
    input wire logic [7:0] sfr_rdata
);
    import ilec_pkg::*;

    // Bus and events idle at time zero
    initial
    begin
        sfr = '0;
        core = '0;
    end

    // Plain store, never read-modify-write, so a racing request survives
    task automatic store(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(negedge clock);
        sfr = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
    endtask

    // Read data is taken one cycle after the strobe
    task automatic load(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        sfr = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
        @(negedge clock);
        d = sfr_rdata;
        sfr = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: 8'hFF};
    endtask

    // One-cycle core event
    task automatic event_pulse(input ilec_core_s e);
        @(negedge clock);
        core = e;
        @(negedge clock);
        core = '0;
    endtask

    // Instruction end after some idle cycles, so slow cores are modelled too
    task automatic finish_instr(input int idle);
        repeat (idle) @(negedge clock);
        event_pulse('{instr_last: 1'h1, default: 1'h0});
    endtask
endmodule

//--- tb/interrupt_latch_enable_control_test.sv
// Self-checking bench for the interrupt latch and enable controller.
// Assumes the core stand-in ilec_core_model; sources are pulsed here on the falling edge.
`timescale 1ns/1ns
module interrupt_latch_enable_control_test;
    import ilec_pkg::*;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic [15:0] src = 16'h0000;
    logic software_trap = 1'h0;
    logic illegal_opcode_trap = 1'h0;
    logic ext_zero_pin_enable = 1'h0;
    logic trap_reset_select = 1'h1;
    ilec_sfr_s sfr;
    ilec_core_s core;
    logic [7:0] sfr_rdata;
    logic [15:0] vector_addr;
    logic accept_busy, accept_done, stacked_mef, reset_request;
    int n_mismatch = 0;
    int n_compared = 0;

    // 25 MHz core clock
    always #20 clock = ~clock;

    // Device and core stand-in; source bit n feeds latch n
    ilec_top DUT (.clock(clock), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(sfr_rdata), .core(core),
        .software_trap(software_trap), .illegal_opcode_trap(illegal_opcode_trap),
        .bad_fetch_trap(src[2]), .watchdog_irq(src[3]), .ext_irq_zero(src[4]), .ext_irq_one(src[5]),
        .time_base_irq(src[6]), .timer_three_irq(src[10]), .timer_four_irq(src[11]),
        .converter_done_irq(src[12]), .ext_irq_five(src[15]), .reserved_irq(src[9:7]),
        .ext_zero_pin_enable(ext_zero_pin_enable), .trap_reset_select(trap_reset_select),
        .accept_busy(accept_busy), .accept_done(accept_done), .vector_addr(vector_addr),
        .stacked_mef(stacked_mef), .reset_request(reset_request));
    ilec_core_model M (.clock(clock), .sfr(sfr), .core(core), .sfr_rdata(sfr_rdata));

    // Compare and count; an unknown never matches
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        M.load(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask

    task automatic pulse(input int i);
        @(negedge clock);
        src[i] = 1'h1;
        @(negedge clock);
        src[i] = 1'h0;
    endtask

    // Acceptance: busy for eight cycles, done on the last
    task automatic take(input logic [15:0] vec);
        M.finish_instr(0);
        chk(accept_busy, 16'h0001);
        chk(vector_addr, vec);
        repeat (7) @(negedge clock);
        chk(accept_done, 16'h0001);
        @(negedge clock);
        chk(accept_busy, 16'h0000);
    endtask

    task automatic t_reset();
        chk(vector_addr, 16'hFFFE);
        for (int a = 8'h3A; a < 8'h3E; a++)
            chk_reg(8'(a), 8'h00);
        chk_reg(8'h40, 8'h00);
    endtask

    task automatic t_enable();
        M.store(ILEC_ADDR_EN_LO, 8'hFF);
        chk_reg(ILEC_ADDR_EN_LO, 8'hF1);
        M.store(ILEC_ADDR_EN_HI, 8'h5A);
        chk_reg(ILEC_ADDR_EN_HI, 8'h5A);
        M.store(ILEC_ADDR_EN_LO, 8'h00);
        M.store(ILEC_ADDR_EN_HI, 8'h00);
    endtask

    task automatic t_latch();
        pulse(5);
        pulse(6);
        chk_reg(ILEC_ADDR_PEND_LO, 8'h60);
        M.store(ILEC_ADDR_PEND_LO, 8'hFF);
        chk_reg(ILEC_ADDR_PEND_LO, 8'h60);
        M.store(ILEC_ADDR_PEND_LO, 8'hDF);
        chk_reg(ILEC_ADDR_PEND_LO, 8'h40);
        @(negedge clock);
        src[2] = 1'h1;
        #1;
        chk(reset_request, 16'h0001);
        pulse(2);
        chk_reg(ILEC_ADDR_PEND_LO, 8'h40);
        trap_reset_select = 1'h0;
        src[3] = 1'h1;
        #1;
        chk(reset_request, 16'h0000);
        pulse(3);
        M.store(ILEC_ADDR_PEND_LO, 8'h00);
        chk_reg(ILEC_ADDR_PEND_LO, 8'h08);
    endtask

    task automatic t_mask();
        take(16'hFFF8);
        chk_reg(ILEC_ADDR_PEND_LO, 8'h00);
        pulse(5);
        M.finish_instr(0);
        chk(accept_busy, 16'h0000);
        M.store(ILEC_ADDR_EN_LO, 8'h20);
        M.finish_instr(2);
        chk(accept_busy, 16'h0000);
        M.event_pulse('{enable_op: 1'h1, default: 1'h0});
        chk_reg(ILEC_ADDR_EN_LO, 8'h21);
        take(16'hFFF4);
        chk(stacked_mef, 16'h0001);
        chk_reg(ILEC_ADDR_EN_LO, 8'h20);
        chk_reg(ILEC_ADDR_PEND_LO, 8'h00);
        M.event_pulse('{return_op: 1'h1, return_mef: 1'h1, default: 1'h0});
        chk_reg(ILEC_ADDR_EN_LO, 8'h21);
        M.event_pulse('{disable_op: 1'h1, default: 1'h0});
        chk_reg(ILEC_ADDR_EN_LO, 8'h20);
    endtask

    task automatic t_vectors();
        M.store(ILEC_ADDR_EN_LO, 8'hFF);
        pulse(4);
        M.finish_instr(0);
        chk(accept_busy, 16'h0000);
        ext_zero_pin_enable = 1'h1;
        M.store(ILEC_ADDR_EN_HI, 8'hFF);
        for (int i = 4; i < 16; i++)
        begin
            M.store(ILEC_ADDR_EN_LO, 8'hFF);
            pulse(i);
            if (i == 13 || i == 14)
            begin
                // Reserved slots 13 and 14 have no request input, so nothing may be taken
                M.finish_instr(0);
                chk(accept_busy, 16'h0000);
            end
            else
                take(16'hFFF6 - 16'(2 * (i - 4)));
        end
    endtask

    task automatic t_prio();
        M.store(ILEC_ADDR_EN_LO, 8'hFF);
        pulse(15);
        pulse(5);
        take(16'hFFF4);
        M.store(ILEC_ADDR_EN_LO, 8'hFF);
        software_trap = 1'h1;
        take(16'hFFFC);
        software_trap = 1'h0;
        chk_reg(ILEC_ADDR_PEND_HI, 8'h80);
        M.store(ILEC_ADDR_EN_LO, 8'hFF);
        take(16'hFFE0);
    endtask

    task automatic t_illegal();
        M.store(ILEC_ADDR_EN_LO, 8'hFF);
        pulse(5);
        M.finish_instr(0);
        illegal_opcode_trap = 1'h1;
        @(negedge clock);
        illegal_opcode_trap = 1'h0;
        chk(vector_addr, 16'hFFFC);
        for (int k = 0; k < 20 && accept_busy !== 1'h0; k++)
            @(negedge clock);
        chk(accept_busy, 16'h0000);
    endtask

    // Hardware set and software clear meet at one edge
    task automatic t_race();
        pulse(6);
        fork
            M.store(ILEC_ADDR_PEND_LO, 8'hBF);
            pulse(6);
        join
        chk_reg(ILEC_ADDR_PEND_LO, 8'h40);
    endtask

    task automatic wrap_up();
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Main sequence after a 16-cycle reset
    initial
    begin
        repeat (16) @(negedge clock);
        rst_n = 1'h1;
        t_reset();
        t_enable();
        t_latch();
        t_mask();
        t_vectors();
        t_prio();
        t_illegal();
        t_race();
        wrap_up();
    end

    // Hang guard, well beyond the few hundred cycles the run needs
    initial
    begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        wrap_up();
    end
endmodule
